// ### i2cbf_pkg.sv
package i2cbf_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [27:0] BFM_INDEX = 28'hFFFFD8A;
    localparam logic [27:0] CTRL_INDEX = 28'h0000010;
    localparam logic [27:0] IRQ_STAT_INDEX = 28'h0000011;
    localparam logic [27:0] IRQ_EN_INDEX = 28'h0000012;
    localparam logic [27:0] IRQ_CLR_INDEX = 28'h0000013;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_STOP_BIT = 2;
    localparam int CTRL_HOLD_BIT = 3;

    // Interrupt status fields
    localparam int IRQ_START_BIT = 0;
    localparam int IRQ_STOP_BIT = 1;
    localparam int IRQ_FAIL_BIT = 2;
    localparam int IRQ_W = 3;

    // Reset values
    localparam logic [7:0] BFM_RESET = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

    // Timing of generated start and stop
    localparam int CLK_PERIOD_NS = 10;
    localparam int START_HOLD_NS = 4000;
    localparam int STOP_SETUP_NS = 4000;
    localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_SETUP_CYC = (STOP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // Bus flag and mode register layout
    typedef struct packed {
        logic start_failure_flag;
        logic bus_busy_flag;
        logic [3:0] zero;
        logic initial_start_permission;
        logic reservation_disable;
    } i2cbf_flag_t;

    // Conditions seen on the bus
    typedef struct packed {
        logic start;
        logic stop;
    } i2cbf_cond_t;

    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
    } i2cbf_dphase_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START_SDA,
        ST_HOLD,
        ST_STOP_SCL
    } i2cbf_state_t;

    function automatic logic [31:0] i2cbf_byte_addr(input logic [27:0] index);
        return {2'b00, index, 2'b00};
    endfunction

endpackage

// ### i2cbf_sync.sv
`timescale 1ns/1ps
module i2cbf_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    // Two flops; idle bus lines are high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // i2cbf_sync

// ### i2cbf_cond_det.sv
`timescale 1ns/1ps
module i2cbf_cond_det
    import i2cbf_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Synchronised bus levels
    input wire logic scl,
    input wire logic sda,
    // Detected conditions
    output i2cbf_cond_t cond
);
    import i2cbf_pkg::*;

    logic sda_q;
    i2cbf_cond_t next_cond;

    // Data edge while clock high marks a condition
    always_comb begin
        next_cond.start = scl & sda_q & ~sda;
        next_cond.stop = scl & ~sda_q & sda;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_q <= 1'b1;
            cond <= '0;
        end else begin
            sda_q <= sda;
            cond <= next_cond;
        end
    end
endmodule // i2cbf_cond_det

// ### i2cbf_top.sv
`timescale 1ns/1ps
module i2cbf_top #(
    parameter int START_CYC = i2cbf_pkg::START_HOLD_CYC,
    parameter int STOP_CYC = i2cbf_pkg::STOP_SETUP_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // I2C pins
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Interrupt
    output logic irq
);
    import i2cbf_pkg::*;

    localparam logic [CNT_W-1:0] START_LOAD = CNT_W'(START_CYC - 1);
    localparam logic [CNT_W-1:0] STOP_LOAD = CNT_W'(STOP_CYC - 1);

    logic [1:0] pins_sync;
    i2cbf_cond_t cond;

    i2cbf_flag_t flags, next_flags;
    logic ctrl_en, next_ctrl_en;
    logic en_q, next_en_q;
    logic start_req, next_start_req;
    logic stop_req, next_stop_req;
    i2cbf_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic next_scl_oe, next_sda_oe;
    logic [IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [IRQ_W-1:0] irq_en, next_irq_en;
    i2cbf_dphase_t dphase, next_dphase;
    logic [31:0] next_hrdata;

    logic wr_lane0;
    logic wr_flag;
    logic wr_ctrl;
    logic wr_irq_en;
    logic wr_irq_clr;
    logic fail_ev;
    logic [IRQ_W-1:0] irq_ev;
    logic ap_take;

    // Bus lines pass two flops before any logic
    i2cbf_sync #(
        .W(2)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_sync)
    );

    i2cbf_cond_det u_det (
        .hclk(hclk),
        .hresetn(hresetn),
        .scl(pins_sync[1]),
        .sda(pins_sync[0]),
        .cond(cond)
    );

    function automatic logic hit(input logic [31:0] addr, input logic [27:0] index);
        return addr[31:2] == {2'b00, index};
    endfunction

    // Open-drain pins only pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(irq_stat & irq_en);

    always_comb begin
        next_flags = flags;
        next_ctrl_en = ctrl_en;
        next_en_q = ctrl_en;
        next_start_req = start_req;
        next_stop_req = stop_req;
        next_state = state;
        next_cnt = cnt;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_irq_en = irq_en;
        next_hrdata = hrdata;
        fail_ev = 1'b0;

        // Data phase of a captured write; lane 0 carries every field
        wr_lane0 = dphase.valid & dphase.write & (dphase.addr[1:0] == 2'b00);
        wr_flag = wr_lane0 & hit(dphase.addr, BFM_INDEX);
        wr_ctrl = wr_lane0 & hit(dphase.addr, CTRL_INDEX);
        wr_irq_en = wr_lane0 & hit(dphase.addr, IRQ_EN_INDEX);
        wr_irq_clr = wr_lane0 & hit(dphase.addr, IRQ_CLR_INDEX);

        // Control register
        if (wr_ctrl) begin
            next_ctrl_en = hwdata[CTRL_EN_BIT];
            if (hwdata[CTRL_START_BIT]) begin
                next_start_req = 1'b1;
                next_flags.start_failure_flag = 1'b0;
            end
            if (hwdata[CTRL_STOP_BIT] && state == ST_HOLD) begin
                next_stop_req = 1'b1;
            end
        end

        // Permission dropped by a start seen on the bus; a mode write in the same cycle wins
        if (cond.start) begin
            next_flags.initial_start_permission = 1'b0;
        end

        // Mode bits written only while stopped; upper flags ignore writes
        if (wr_flag && !ctrl_en) begin
            next_flags.initial_start_permission = hwdata[1];
            next_flags.reservation_disable = hwdata[0];
        end

        // Busy tracking
        if (ctrl_en) begin
            if (cond.stop) begin
                next_flags.bus_busy_flag = 1'b0;
            end
            if (cond.start) begin
                next_flags.bus_busy_flag = 1'b1;
            end
            if (!en_q && !flags.initial_start_permission) begin
                next_flags.bus_busy_flag = 1'b1;
            end
        end

        // Start and stop generation
        case (state)
            ST_IDLE: begin
                if (ctrl_en && start_req) begin
                    if (!flags.bus_busy_flag) begin
                        next_sda_oe = 1'b1;
                        next_cnt = START_LOAD;
                        next_state = ST_START_SDA;
                    end else if (flags.reservation_disable) begin
                        fail_ev = 1'b1;
                        next_start_req = 1'b0;
                    end
                end
            end
            ST_START_SDA: begin
                if (cnt == '0) begin
                    next_scl_oe = 1'b1;
                    next_start_req = 1'b0;
                    next_state = ST_HOLD;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            ST_HOLD: begin
                if (stop_req) begin
                    next_scl_oe = 1'b0;
                    next_cnt = STOP_LOAD;
                    next_state = ST_STOP_SCL;
                end
            end
            ST_STOP_SCL: begin
                if (cnt == '0) begin
                    next_sda_oe = 1'b0;
                    next_stop_req = 1'b0;
                    next_state = ST_IDLE;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // Failure set wins over the clear by a new request
        if (fail_ev) begin
            next_flags.start_failure_flag = 1'b1;
        end

        // Stopped controller drops flags, requests and pins
        if (!ctrl_en) begin
            next_flags.bus_busy_flag = 1'b0;
            next_flags.start_failure_flag = 1'b0;
            next_start_req = 1'b0;
            next_stop_req = 1'b0;
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_state = ST_IDLE;
        end
        next_flags.zero = 4'h0;

        // Interrupts: sticky, events win over clears
        irq_ev = '0;
        irq_ev[IRQ_START_BIT] = cond.start;
        irq_ev[IRQ_STOP_BIT] = cond.stop;
        irq_ev[IRQ_FAIL_BIT] = fail_ev;
        next_irq_stat = irq_stat;
        if (wr_irq_clr) begin
            next_irq_stat = irq_stat & ~hwdata[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | irq_ev;
        if (wr_irq_en) begin
            next_irq_en = hwdata[IRQ_W-1:0];
        end

        // Address phase capture
        ap_take = hsel & hready & htrans[1];
        next_dphase.valid = ap_take;
        next_dphase.write = ap_take & hwrite;
        next_dphase.addr = ap_take ? haddr : dphase.addr;

        // Read data from next values so a read after a write sees it
        if (ap_take && !hwrite) begin
            if (hit(haddr, BFM_INDEX)) begin
                next_hrdata = {24'h000000, next_flags};
            end else if (hit(haddr, CTRL_INDEX)) begin
                next_hrdata = '0;
                next_hrdata[CTRL_EN_BIT] = next_ctrl_en;
                next_hrdata[CTRL_START_BIT] = next_start_req;
                next_hrdata[CTRL_STOP_BIT] = next_stop_req;
                next_hrdata[CTRL_HOLD_BIT] = (next_state == ST_HOLD);
            end else if (hit(haddr, IRQ_STAT_INDEX)) begin
                next_hrdata = {{(32-IRQ_W){1'b0}}, next_irq_stat};
            end else if (hit(haddr, IRQ_EN_INDEX)) begin
                next_hrdata = {{(32-IRQ_W){1'b0}}, next_irq_en};
            end else begin
                next_hrdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags <= i2cbf_flag_t'(BFM_RESET);
            ctrl_en <= 1'b0;
            en_q <= 1'b0;
            start_req <= 1'b0;
            stop_req <= 1'b0;
            state <= ST_IDLE;
            cnt <= '0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            irq_stat <= IRQ_RESET;
            irq_en <= IRQ_RESET;
            dphase <= '0;
            hrdata <= 32'h00000000;
        end else begin
            flags <= next_flags;
            ctrl_en <= next_ctrl_en;
            en_q <= next_en_q;
            start_req <= next_start_req;
            stop_req <= next_stop_req;
            state <= next_state;
            cnt <= next_cnt;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            dphase <= next_dphase;
            hrdata <= next_hrdata;
        end
    end
endmodule // i2cbf_top

// ### i2cbf_top_props.sv
`timescale 1ns/1ps
module i2cbf_top_props #(
    parameter int START_CYC = 4,
    parameter int STOP_CYC = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Pins
    input wire logic scl_in,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic irq
);
    import i2cbf_pkg::*;
    localparam int S_MIN = START_CYC - 1;
    localparam int S_MAX = START_CYC + 2;
    localparam int P_MIN = STOP_CYC - 1;
    localparam int P_MAX = STOP_CYC + 2;
    logic take;
    logic rd_flag;
    logic wr_ctl;
    assign take = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_flag <= 1'b0;
            wr_ctl <= 1'b0;
        end else begin
            rd_flag <= take && !hwrite && haddr == {2'h0, BFM_INDEX, 2'h0};
            wr_ctl <= take && hwrite && haddr == {2'h0, CTRL_INDEX, 2'h0};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reset_quiet_a: assert property ($rose(hresetn) |-> !irq && !scl_oe && !sda_oe && hrdata == 32'h0)
        else $error("Outputs busy after reset");
    flag_zero_a: assert property (rd_flag |-> hrdata[31:8] == 24'h0 && hrdata[5:2] == 4'h0)
        else $error("Unused flag bits set");
    fail_rsv_a: assert property (rd_flag && hrdata[7] |-> hrdata[0])
        else $error("Failure flag with reservation on");
    rdata_hold_a: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("Read data moved without a read");
    start_shape_a: assert property ($rose(sda_oe) |-> !scl_oe && scl_in)
        else $error("Start drawn with clock low");
    start_hold_a: assert property ($rose(sda_oe) |-> ##[S_MIN:S_MAX] $rose(scl_oe))
        else $error("Start hold time wrong");
    stop_shape_a: assert property ($fell(scl_oe) && sda_oe |-> ##[P_MIN:P_MAX] $fell(sda_oe))
        else $error("Stop setup time wrong");
    dis_drop_a: assert property (wr_ctl && !hwdata[0] |-> ##[1:2] !scl_oe && !sda_oe)
        else $error("Pins held after disable");
endmodule // i2cbf_top_props

bind i2cbf_top i2cbf_top_props #(.START_CYC(START_CYC), .STOP_CYC(STOP_CYC)) i2cbf_top_props_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .scl_in, .scl_oe, .sda_oe, .irq);

// ### i2cbf_peer.sv
`timescale 1ns/1ps
module i2cbf_peer #(
    parameter int T = 10
) (
    // Clock
    input wire logic hclk,
    // Open-drain pulls, high pulls the line low
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic step(input logic c, input logic d);
        @(posedge hclk);
        scl_low <= c;
        sda_low <= d;
        repeat (T) @(posedge hclk);
    endtask
    // Start: data falls while clock high, clock then held low
    task automatic start_c;
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
    endtask
    // Stop: data rises while clock high, both lines released
    task automatic stop_c;
        step(1'b1, sda_low);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b0);
    endtask
endmodule // i2cbf_peer

// ### i2cbf_top_tb.sv
`timescale 1ns/1ps
module i2cbf_top_tb;
    import i2cbf_pkg::*;
    localparam logic [31:0] FA = {2'h0, BFM_INDEX, 2'h0};
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, irq, rd_dp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, wd;
    logic scl_oe, sda_oe, pscl, psda;
    logic [32:0] q[$];
    int n_mismatch, compares, seed;
    wire scl_in = !(scl_oe || pscl);
    wire sda_in = !(sda_oe || psda);
    assign hready = hreadyout;
    i2cbf_top #(.START_CYC(4), .STOP_CYC(4)) i2cbf_top_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp(), .hrdata, .scl_in, .scl_out(), .scl_oe, .sda_in,
        .sda_out(), .sda_oe, .irq);
    i2cbf_peer i2cbf_peer_inst (.hclk, .scl_low(pscl), .sda_low(psda));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic end_sim;
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    always @(posedge hclk) begin
        if (rd_dp) begin
            check({irq, hrdata}, q.pop_front());
        end
    end
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            end_sim;
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        input logic [32:0] e);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !w;
        if (!w) q.push_back(e);
        wait_rdy;
        rd_dp <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [31:0] a, input logic i, input logic [7:0] d);
        xfer(1'b0, a, 32'h0, {i, 24'h0, d});
    endtask
    initial begin
        seed = 32'hFA855394;
        n_mismatch = 0;
        compares = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_dp = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(FA, 1'b0, 8'h00);
        rd(32'h40, 1'b0, 8'h00);
        wd = $random(seed);
        wr(FA, wd);
        rd(FA, 1'b0, {6'h0, wd[1:0]});
        rd(32'h100, 1'b0, 8'h00);
        $display("Layout test done");
        wr(FA, 32'h0);
        wr(32'h48, 32'h7);
        wr(32'h40, 32'h1);
        wr(FA, 32'h3);
        rd(FA, 1'b0, 8'h40);
        i2cbf_peer_inst.stop_c;
        repeat (8) @(posedge hclk);
        rd(FA, 1'b1, 8'h00);
        rd(32'h44, 1'b1, 8'h02);
        wr(32'h4C, 32'h7);
        rd(32'h44, 1'b0, 8'h00);
        $display("Busy test done");
        i2cbf_peer_inst.start_c;
        repeat (8) @(posedge hclk);
        rd(FA, 1'b1, 8'h40);
        wr(32'h40, 32'h0);
        rd(FA, 1'b1, 8'h00);
        wr(FA, 32'h1);
        wr(32'h40, 32'h1);
        wr(32'h40, 32'h3);
        rd(FA, 1'b1, 8'hC1);
        rd(32'h40, 1'b1, 8'h01);
        rd(32'h44, 1'b1, 8'h05);
        i2cbf_peer_inst.stop_c;
        repeat (8) @(posedge hclk);
        rd(FA, 1'b1, 8'h81);
        wr(32'h40, 32'h3);
        repeat (20) @(posedge hclk);
        rd(FA, 1'b1, 8'h41);
        wr(32'h40, 32'h5);
        repeat (20) @(posedge hclk);
        rd(FA, 1'b1, 8'h01);
        $display("Failure test done");
        wr(32'h40, 32'h0);
        wr(FA, 32'h2);
        wr(32'h40, 32'h1);
        rd(FA, 1'b1, 8'h02);
        wr(32'h40, 32'h3);
        repeat (20) @(posedge hclk);
        rd(FA, 1'b1, 8'h40);
        wr(32'h40, 32'h0);
        rd(FA, 1'b1, 8'h00);
        wr(32'h48, 32'h0);
        rd(32'h44, 1'b0, 8'h07);
        wr(32'h4C, 32'h7);
        rd(32'h44, 1'b0, 8'h00);
        $display("Permission test done");
        end_sim;
    end
endmodule // i2cbf_top_tb
